/* File: acc_pkg.sv */
package acc_pkg;

  // ****************************************
  // Sizes
  // ****************************************
  localparam int unsigned NUM_CH = 4;
  localparam int unsigned FSEL_W = 2;

  // ****************************************
  // Register offsets (word addresses)
  // ****************************************
  localparam logic [3:0] OFS_ENABLE  = 4'h0;  // Per-channel operation enable
  localparam logic [3:0] OFS_REFSEL  = 4'h1;  // 1 = internal reference
  localparam logic [3:0] OFS_OUTEN   = 4'h2;  // Result pin drive enable
  localparam logic [3:0] OFS_MODE    = 4'h3;  // Window, speed, filter
  localparam logic [3:0] OFS_FLAG    = 4'h4;  // Result flags, read only
  localparam logic [3:0] OFS_IRQ_ST  = 4'h5;  // Sticky change status, read only
  localparam logic [3:0] OFS_IRQ_CLR = 4'h6;  // Write one to clear
  localparam logic [3:0] OFS_IRQ_EN  = 4'h7;  // Interrupt enable

  // ****************************************
  // Mode register fields
  // ****************************************
  localparam int unsigned MODE_WIN_BIT   = 0;
  localparam int unsigned MODE_SPEED_BIT = 1;  // 1 = high speed
  localparam int unsigned MODE_FEN_BIT   = 2;
  localparam int unsigned MODE_FSEL_LSB  = 3;

  // ****************************************
  // Reset values
  // ****************************************
  localparam logic [3:0] ENABLE_RST = 4'h0;
  localparam logic [3:0] REFSEL_RST = 4'h0;
  localparam logic [3:0] OUTEN_RST  = 4'h0;
  localparam logic [4:0] MODE_RST   = 5'h00;
  localparam logic [3:0] IRQEN_RST  = 4'h0;

  // ****************************************
  // Filter sampling dividers (clk cycles per sample)
  // ****************************************
  localparam logic [7:0] FDIV_0 = 8'h01;
  localparam logic [7:0] FDIV_1 = 8'h08;
  localparam logic [7:0] FDIV_2 = 8'h20;
  localparam logic [7:0] FDIV_3 = 8'h80;
  localparam int unsigned FILT_SAMPLES = 3;

endpackage

/* File: acc_filter.sv */
`timescale 1ns/100ps
// ****************************************
// Per-channel majority-free digital filter
// ****************************************
module acc_filter #(
  parameter int unsigned SAMPLES = acc_pkg::FILT_SAMPLES
) (
  // Clock and reset
  input  wire logic clk,
  input  wire logic rst_n,
  // Control
  input  wire logic filt_en,
  input  wire logic sample_en,
  // Data
  input  wire logic raw_in,
  output logic      filt_out
);

  logic [SAMPLES-1:0] hist_q;
  logic               out_q;

  // Shift history on each sample tick
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      hist_q <= '0;
    end else if (sample_en) begin
      hist_q <= {hist_q[SAMPLES-2:0], raw_in};
    end
  end

  // Output moves only after SAMPLES equal samples; bypass follows raw
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      out_q <= 1'b0;
    end else if (!filt_en) begin
      out_q <= raw_in;
    end else if (&hist_q) begin
      out_q <= 1'b1;
    end else if (~|hist_q) begin
      out_q <= 1'b0;
    end
  end

  assign filt_out = out_q;

endmodule

/* File: acc_top.sv */
// The placing of the registers and the strobed register port were chosen for this implementation.
`timescale 1ns/100ps
// Function
// RULE_01 - Four independent channels 0..3 each compare their own analog input with a selected reference.
// RULE_02 - Software picks, per channel, the external reference pin or the internal reference.
// RULE_03 - Each result is a readable flag and can optionally drive a per-channel result pin.
// RULE_04 - Each channel raises its own interrupt request when its result changes.
// RULE_05 - Two events go to the event link controller: channel 0 change, and channel 0 or 1 change.
// RULE_06 - An optional digital filter per result can be enabled or bypassed, with selectable sample rate.
// RULE_07 - Software enables window mode, where a channel reports its input between low and high references.
// RULE_08 - Software selects a high-speed or low-speed comparator response.
// RULE_09 - Without window mode the flag is 1 above the reference and 0 below it.
// RULE_10 - With window mode the flag is 1 inside the window and 0 below or above it.
// RULE_11 - A disabled channel's flag reads 0 whatever the mode.
// RULE_12 - A change is a difference between consecutive filtered samples and gives one-cycle pulses.
module acc_top (
  // Clock and reset
  input  wire logic                      clk,
  input  wire logic                      rst_n,
  // Register port
  input  wire logic [3:0]                reg_addr,
  input  wire logic [7:0]                reg_wdata,
  input  wire logic                      reg_wr,
  input  wire logic                      reg_rd,
  output logic      [7:0]                reg_rdata,
  // Analog front ends (asynchronous comparator outputs)
  input  wire logic [acc_pkg::NUM_CH-1:0] cmp_above_ref,
  input  wire logic [acc_pkg::NUM_CH-1:0] cmp_above_low,
  input  wire logic [acc_pkg::NUM_CH-1:0] cmp_above_high,
  // Front end control
  output logic      [acc_pkg::NUM_CH-1:0] comparator_enable,
  output logic      [acc_pkg::NUM_CH-1:0] ref_internal_sel,
  output logic                           high_speed_mode,
  output logic                           window_mode,
  // Result pins
  output logic      [acc_pkg::NUM_CH-1:0] comparator_result_output,
  output logic      [acc_pkg::NUM_CH-1:0] result_output_oe,
  // Interrupts and events
  output logic      [acc_pkg::NUM_CH-1:0] change_irq_pulse,
  output logic                           irq,
  output logic                           elc_event_ch0,
  output logic                           elc_event_ch01
);

  localparam int unsigned N = acc_pkg::NUM_CH;

  // ****************************************
  // Registers
  // ****************************************
  logic [N-1:0] enable_q;
  logic [N-1:0] refsel_q;
  logic [N-1:0] outen_q;
  logic [4:0]   mode_q;
  logic [N-1:0] irq_st_q;
  logic [N-1:0] irq_en_q;
  logic [7:0]   rdata_q;

  logic         win_en;
  logic         filt_en;
  logic [1:0]   fsel;

  // Mode register fields
  assign win_en  = mode_q[acc_pkg::MODE_WIN_BIT];
  assign filt_en = mode_q[acc_pkg::MODE_FEN_BIT];
  assign fsel    = mode_q[acc_pkg::MODE_FSEL_LSB +: acc_pkg::FSEL_W];

  // Decode used by every write path
  function automatic logic wr_hit(input logic [3:0] a, input logic [3:0] ofs, input logic wr);
    wr_hit = wr && (a == ofs);
  endfunction

  // ****************************************
  // Control registers
  // ****************************************
  // Channel enables; also start and stop the front ends
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      enable_q <= acc_pkg::ENABLE_RST;
    end else if (wr_hit(reg_addr, acc_pkg::OFS_ENABLE, reg_wr)) begin
      enable_q <= reg_wdata[N-1:0];  // [RULE_01]
    end
  end

  // Reference choice; the front end does the switching
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      refsel_q <= acc_pkg::REFSEL_RST;
    end else if (wr_hit(reg_addr, acc_pkg::OFS_REFSEL, reg_wr)) begin
      refsel_q <= reg_wdata[N-1:0];  // [RULE_02]
    end
  end

  // Result pin drive enables
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      outen_q <= acc_pkg::OUTEN_RST;
    end else if (wr_hit(reg_addr, acc_pkg::OFS_OUTEN, reg_wr)) begin
      outen_q <= reg_wdata[N-1:0];  // [RULE_03]
    end
  end

  // Window, speed and filter settings
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      mode_q <= acc_pkg::MODE_RST;
    end else if (wr_hit(reg_addr, acc_pkg::OFS_MODE, reg_wr)) begin
      mode_q <= reg_wdata[4:0];  // [RULE_07] [RULE_08] [RULE_06]
    end
  end

  // Interrupt enables, same layout as the status
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      irq_en_q <= acc_pkg::IRQEN_RST;
    end else if (wr_hit(reg_addr, acc_pkg::OFS_IRQ_EN, reg_wr)) begin
      irq_en_q <= reg_wdata[N-1:0];
    end
  end

  // ****************************************
  // Input synchronisers
  // ****************************************
  logic [N-1:0] ref_s1_q, ref_s2_q;
  logic [N-1:0] low_s1_q, low_s2_q;
  logic [N-1:0] high_s1_q, high_s2_q;

  // Above-reference outputs are asynchronous; two stages before use
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ref_s1_q <= '0;
      ref_s2_q <= '0;
    end else begin
      ref_s1_q <= cmp_above_ref;
      ref_s2_q <= ref_s1_q;
    end
  end

  // Window low-side outputs, same two stages
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      low_s1_q <= '0;
      low_s2_q <= '0;
    end else begin
      low_s1_q <= cmp_above_low;
      low_s2_q <= low_s1_q;
    end
  end

  // Window high-side outputs, same two stages
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      high_s1_q <= '0;
      high_s2_q <= '0;
    end else begin
      high_s1_q <= cmp_above_high;
      high_s2_q <= high_s1_q;
    end
  end

  // ****************************************
  // Filter sample divider
  // ****************************************
  logic [7:0] div_cnt_q;
  logic [7:0] div_lim;
  logic       sample_en;

  // Divider limit from selected sampling rate
  always_comb begin
    case (fsel)
      2'h0:    div_lim = acc_pkg::FDIV_0;
      2'h1:    div_lim = acc_pkg::FDIV_1;
      2'h2:    div_lim = acc_pkg::FDIV_2;
      default: div_lim = acc_pkg::FDIV_3;
    endcase
  end

  // Tick on the last count; a limit of one ticks every clock
  assign sample_en = (div_cnt_q >= div_lim - 8'h01);

  // Free-running divider gives one-cycle sample ticks
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      div_cnt_q <= 8'h00;
    end else if (sample_en) begin
      div_cnt_q <= 8'h00;  // [RULE_06]
    end else begin
      div_cnt_q <= div_cnt_q + 8'h01;
    end
  end

  // ****************************************
  // Per-channel result path
  // ****************************************
  logic [N-1:0] raw_res;
  logic [N-1:0] filt_res;
  logic [N-1:0] flag_q;
  logic [N-1:0] change;

  genvar g;
  generate
    for (g = 0; g < N; g++) begin : g_ch
      // Window: strictly above low and not above high; disabled forces 0
      assign raw_res[g] = enable_q[g] &&  // [RULE_11]
                          (win_en ? (low_s2_q[g] && !high_s2_q[g])  // [RULE_10] [RULE_07]
                                  : ref_s2_q[g]);  // [RULE_09]

      acc_filter u_filt (
        .clk       (clk),
        .rst_n     (rst_n),
        .filt_en   (filt_en),
        .sample_en (sample_en),
        .raw_in    (raw_res[g]),
        .filt_out  (filt_res[g])
      );
    end
  endgenerate

  // Disable also clears the flag at once, bypassing filter latency
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      flag_q <= '0;
    end else begin
      flag_q <= filt_res & enable_q;  // [RULE_03] [RULE_11]
    end
  end

  // Change against the last flag; a disable itself gives a 1 to 0 change
  assign change = (filt_res & enable_q) ^ flag_q;  // [RULE_12]

  // ****************************************
  // Interrupts and events
  // ****************************************
  logic [N-1:0] pulse_q;
  logic         ev0_q;
  logic         ev01_q;
  logic         irq_q;
  logic [N-1:0] clr_mask;
  logic [N-1:0] st_next;

  // Clear mask only during a write to the clear offset
  assign clr_mask = wr_hit(reg_addr, acc_pkg::OFS_IRQ_CLR, reg_wr) ? reg_wdata[N-1:0] : '0;

  // Next status; a new change wins over a clear in the same cycle
  assign st_next = (irq_st_q & ~clr_mask) | change;  // [RULE_04]

  // One-cycle change pulses, one per channel
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pulse_q <= '0;
    end else begin
      pulse_q <= change;  // [RULE_04] [RULE_12]
    end
  end

  // Event link pulses; channel 0 alone, and channel 0 or 1
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ev0_q  <= 1'b0;
      ev01_q <= 1'b0;
    end else begin
      ev0_q  <= change[0];  // [RULE_05]
      ev01_q <= change[0] | change[1];  // [RULE_05]
    end
  end

  // Sticky status, held until software clears it
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      irq_st_q <= '0;
    end else begin
      irq_st_q <= st_next;  // [RULE_04]
    end
  end

  // Level interrupt from next status, so it drops with the clear
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      irq_q <= 1'b0;
    end else begin
      irq_q <= |(st_next & irq_en_q);  // [RULE_04]
    end
  end

  // ****************************************
  // Read port
  // ****************************************
  // Unmapped offsets read zero
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rdata_q <= 8'h00;
    end else if (reg_rd) begin
      case (reg_addr)
        acc_pkg::OFS_ENABLE: rdata_q <= {4'h0, enable_q};
        acc_pkg::OFS_REFSEL: rdata_q <= {4'h0, refsel_q};
        acc_pkg::OFS_OUTEN:  rdata_q <= {4'h0, outen_q};
        acc_pkg::OFS_MODE:   rdata_q <= {3'h0, mode_q};
        acc_pkg::OFS_FLAG:   rdata_q <= {4'h0, flag_q};  // [RULE_03]
        acc_pkg::OFS_IRQ_ST: rdata_q <= {4'h0, irq_st_q};
        acc_pkg::OFS_IRQ_EN: rdata_q <= {4'h0, irq_en_q};
        default:             rdata_q <= 8'h00;
      endcase
    end else begin
      rdata_q <= 8'h00;
    end
  end

  // ****************************************
  // Output pins
  // ****************************************
  logic [N-1:0] res_out_q;
  logic [N-1:0] oe_q;

  // Pin level follows the flag one cycle later, after its pulse
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      res_out_q <= '0;
    end else begin
      res_out_q <= flag_q & outen_q;  // [RULE_03]
    end
  end

  // Drive enable in step with the pin level, so no stale level leaks out
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      oe_q <= '0;
    end else begin
      oe_q <= outen_q;  // [RULE_03]
    end
  end

  // Every port straight from a flop
  assign reg_rdata                = rdata_q;
  assign comparator_enable        = enable_q;
  assign ref_internal_sel         = refsel_q;  // [RULE_02]
  assign high_speed_mode          = mode_q[acc_pkg::MODE_SPEED_BIT];  // [RULE_08]
  assign window_mode              = win_en;
  assign comparator_result_output = res_out_q;
  assign result_output_oe         = oe_q;
  assign change_irq_pulse         = pulse_q;
  assign irq                      = irq_q;
  assign elc_event_ch0            = ev0_q;
  assign elc_event_ch01           = ev01_q;

endmodule

/* File: acc_monitor.sv */
`timescale 1ns/100ps
// ****************************************
// Port checker
// ****************************************
module acc_chk (
  // Clock and reset
  input wire logic       clk,
  input wire logic       rst_n,
  // Register port
  input wire logic [3:0] reg_addr,
  input wire logic       reg_wr,
  input wire logic       reg_rd,
  input wire logic [7:0] reg_rdata,
  // Results
  input wire logic [3:0] comparator_enable,
  input wire logic [3:0] comparator_result_output,
  input wire logic [3:0] result_output_oe,
  input wire logic [3:0] change_irq_pulse,
  input wire logic       irq,
  input wire logic       elc_event_ch0,
  input wire logic       elc_event_ch01
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  property p_rd_idle; !$past(reg_rd) |-> reg_rdata == 8'h00; endproperty
  a_rd_idle: assert property (p_rd_idle)
    else $error("read data outside read cycle");
  property p_flag_w; $past(reg_rd && reg_addr == acc_pkg::OFS_FLAG) |-> reg_rdata[7:4] == 4'h0; endproperty
  a_flag_w: assert property (p_flag_w)
    else $error("flag read wider than four channels");
  property p_ev0; elc_event_ch0 == change_irq_pulse[0]; endproperty
  a_ev0: assert property (p_ev0)
    else $error("channel 0 event mismatch");
  property p_ev01; elc_event_ch01 == (change_irq_pulse[0] || change_irq_pulse[1]); endproperty
  a_ev01: assert property (p_ev01)
    else $error("channel 0 or 1 event mismatch");
  property p_pulse; change_irq_pulse[0] |=> !change_irq_pulse[0]; endproperty
  a_pulse: assert property (p_pulse)
    else $error("change pulse longer than one cycle");
  property p_pin_oe; (comparator_result_output & ~result_output_oe) == 4'h0; endproperty
  a_pin_oe: assert property (p_pin_oe)
    else $error("result pin high while not driven");
  property p_pin_chg; $changed(comparator_result_output[0]) && $stable(result_output_oe[0]) && result_output_oe[0]
    |-> $past(change_irq_pulse[0]); endproperty
  a_pin_chg: assert property (p_pin_chg)
    else $error("pin change without change pulse");
  property p_dis; (comparator_result_output & ~$past(comparator_enable) & ~$past(comparator_enable, 2)) == 4'h0;
  endproperty
  a_dis: assert property (p_dis)
    else $error("disabled channel shows a result");
  property p_irq_up; $rose(irq) |-> (|change_irq_pulse) || $past(reg_wr) || $past(reg_wr, 2); endproperty
  a_irq_up: assert property (p_irq_up)
    else $error("interrupt rose without cause");
  property p_irq_dn; $fell(irq) |-> $past(reg_wr) || $past(reg_wr, 2); endproperty
  a_irq_dn: assert property (p_irq_dn)
    else $error("interrupt fell without a write");
endmodule
bind acc_top acc_chk i_chk (.clk, .rst_n, .reg_addr, .reg_wr, .reg_rd, .reg_rdata, .comparator_enable,
  .comparator_result_output, .result_output_oe, .change_irq_pulse, .irq, .elc_event_ch0, .elc_event_ch01);

/* File: acc_fe_model.sv */
`timescale 1ns/100ps
// ****************************************
// Comparator front end model
// ****************************************
module acc_fe_model #(
  parameter logic [7:0] INT_REF  = 8'h80,
  parameter logic [7:0] LOW_REF  = 8'h40,
  parameter logic [7:0] HIGH_REF = 8'hc0
) (
  // Clock
  input wire logic            clk,
  // Control
  input wire logic [3:0]      comparator_enable,
  input wire logic [3:0]      ref_internal_sel,
  // Analog levels
  input wire logic [3:0][7:0] comparator_analog_input,
  input wire logic [3:0][7:0] comparator_reference_input,
  // Comparator outputs
  output logic     [3:0]      above_ref,
  output logic     [3:0]      above_low,
  output logic     [3:0]      above_high
);
  // A stopped comparator rests high and inside the window, so the block
  // must mask it; a steady level keeps one clean edge at each enable
  always_ff @(posedge clk) begin
    for (int i = 0; i < 4; i++) begin
      if (comparator_enable[i]) begin
        above_ref[i]  <= comparator_analog_input[i] >
          (ref_internal_sel[i] ? INT_REF : comparator_reference_input[i]);
        above_low[i]  <= comparator_analog_input[i] > LOW_REF;
        above_high[i] <= comparator_analog_input[i] > HIGH_REF;
      end else begin
        above_ref[i]  <= 1'b1;
        above_low[i]  <= 1'b1;
        above_high[i] <= 1'b0;
      end
    end
  end
endmodule

/* File: tb.sv */
`timescale 1ns/100ps
// ****************************************
// Testbench
// ****************************************
module tb;
  logic clk = 1'b0, rst_n = 1'b0, reg_wr, reg_rd, pend = 1'b0;
  logic [3:0] reg_addr, m, f0, f1, d;
  logic [7:0] reg_wdata, reg_rdata, exp_q[$], cfg[8];
  logic [3:0][7:0] ain, aref;
  logic [3:0] cen, rsel, pin, poe, pls, ab_r, ab_l, ab_h;
  logic hsm, win, irq, ev0, ev01;
  int miscompares = 0, samples_checked = 0, c0 = 0, c01 = 0, s0, s01, cp = 0, sp;
  always #10 clk = ~clk;
  acc_top i_dut (.clk(clk), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .cmp_above_ref(ab_r), .cmp_above_low(ab_l), .cmp_above_high(ab_h),
    .comparator_enable(cen), .ref_internal_sel(rsel), .high_speed_mode(hsm), .window_mode(win),
    .comparator_result_output(pin), .result_output_oe(poe), .change_irq_pulse(pls), .irq(irq),
    .elc_event_ch0(ev0), .elc_event_ch01(ev01));
  acc_fe_model i_fe (.clk(clk), .comparator_enable(cen), .ref_internal_sel(rsel), .comparator_analog_input(ain),
    .comparator_reference_input(aref), .above_ref(ab_r), .above_low(ab_l), .above_high(ab_h));
  task automatic chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      miscompares++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic wt(input int n);
    repeat (n) @(posedge clk);
  endtask
  task automatic wr(input logic [3:0] a, input logic [7:0] v);
    @(posedge clk);
    reg_wr <= 1'b1; reg_addr <= a; reg_wdata <= v;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(input logic [3:0] a, input logic [7:0] e);
    @(posedge clk);
    reg_rd <= 1'b1; reg_addr <= a;
    @(posedge clk);
    exp_q.push_back(e);
    reg_rd <= 1'b0;
  endtask
  // Expected flags; odd inputs against even references avoid ties
  function automatic logic [3:0] calc(input logic [3:0][7:0] v);
    logic [3:0] f;
    for (int i = 0; i < 4; i++)
      f[i] = cfg[0][i] && (cfg[3][0] ? (v[i] > 8'h40 && v[i] < 8'hc0) : v[i] > (cfg[1][i] ? 8'h80 : aref[i]));
    return f;
  endfunction
  task automatic conclude;
    $display("checked %0d miscompares %0d", samples_checked, miscompares);
    if (miscompares == 0 && samples_checked > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  // Read data one cycle after the strobe; event counts on every clock
  always @(posedge clk) begin
    if (pend) chk("rdata", reg_rdata, exp_q.pop_front());
    pend <= reg_rd;
    c0 <= c0 + int'(ev0);
    c01 <= c01 + int'(ev01);
    cp <= cp + $countones(pls);
  end
  initial begin
    #2000000;
    miscompares++;
    conclude();
  end
  initial begin
    reg_wr <= 1'b0; reg_rd <= 1'b0; reg_addr <= 4'h0; reg_wdata <= 8'h00; ain <= '0; aref <= '0;
    void'($urandom(32'h319d));
    wt(8);
    rst_n <= 1'b1;
    for (int a = 0; a < 16; a++) rd(4'(a), 8'h00);
    wr(4'h9, 8'hff); rd(4'h9, 8'h00); rd(4'h0, 8'h00);
    for (int t = 0; t < 16; t++) begin
      for (int a = 0; a < 8; a++) cfg[a] = 8'($urandom) & (a == 3 ? 8'h1f : 8'h0f);
      for (int i = 0; i < 4; i++) aref[i] <= 8'($urandom) & 8'hfe;
      for (int a = 0; a < 4; a++) begin
        wr(4'(a), cfg[a]); rd(4'(a), cfg[a]);
      end
      wr(4'h7, cfg[7]); rd(4'h7, cfg[7]);
      wt(600);
      wr(4'h6, 8'h0f); rd(4'h6, 8'h00);
      chk("enable", 8'(cen), cfg[0]);
      chk("refsel", 8'(rsel), cfg[1]);
      chk("mode", 8'({hsm, win}), cfg[3] & 8'h03);
      f0 = calc(ain);
      rd(4'h4, 8'(f0));
      s0 = c0; s01 = c01;
      sp = cp;
      for (int i = 0; i < 4; i++) ain[i] <= 8'($urandom) | 8'h01;
      wt(1);
      f1 = calc(ain);
      d = f0 ^ f1;
      wt(600);
      rd(4'h4, 8'(f1));
      rd(4'h5, 8'(d));
      chk("irq", 8'(irq), 8'(|(d & cfg[7][3:0])));
      chk("ev0", 8'(c0 - s0), 8'(d[0]));
      chk("ev01", 8'(c01 - s01), 8'(d[0] | d[1]));
      chk("pulses", 8'(cp - sp), 8'($countones(d)));
      chk("pin", 8'(pin), 8'(f1 & cfg[2][3:0]));
      chk("oe", 8'(poe), cfg[2]);
      m = 4'($urandom);
      wr(4'h6, 8'(m)); rd(4'h5, 8'(d & ~m));
      chk("irq", 8'(irq), 8'(|(d & ~m & cfg[7][3:0])));
    end
    wt(2);
    conclude();
  end
endmodule
